// ===== src/mpc_pkg.sv
// constants shared by the multichannel pwm control block
package mpc_pkg;

  // ---------------------------------------------------------------
  // channel counts
  // ---------------------------------------------------------------
  localparam int CH_NUM  = 6;
  localparam int INC_NUM = 5;
  localparam int IN_NUM  = 4;

  // ---------------------------------------------------------------
  // register address codes (bits 15:12 of a frame)
  // ---------------------------------------------------------------
  localparam logic [3:0] ADR_INIT2    = 4'h1;
  localparam logic [3:0] ADR_CH_FIRST = 4'h2;
  localparam logic [3:0] ADR_CH_LAST  = 4'h7;
  localparam logic [3:0] ADR_OUTCTL   = 4'h8;
  localparam logic [3:0] ADR_GLOBAL   = 4'h9;
  localparam logic [3:0] ADR_INEN     = 4'hb;
  localparam logic [3:0] ADR_PRESC    = 4'hc;
  localparam logic [3:0] ADR_INCR     = 4'he;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int ADR_MSB   = 15;
  localparam int ADR_LSB   = 12;
  localparam int WATCH_BIT = 11;
  localparam int SEL_BIT   = 10;
  localparam int PH_MSB    = 10;
  localparam int PH_LSB    = 9;
  localparam int ON_BIT    = 8;
  localparam int DUTY_MSB  = 7;
  localparam int SYNC_BIT  = 1;
  localparam int SGN_BIT   = 10;
  localparam int PH_SHIFT  = 6;

  // ---------------------------------------------------------------
  // encodings and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] DIV_BY4   = 2'b00;
  localparam logic [1:0] DIV_BY2   = 2'b01;
  localparam logic [1:0] STEP_NONE = 2'b00;
  localparam logic [1:0] STEP_4    = 2'b01;
  localparam logic [1:0] STEP_8    = 2'b10;
  localparam logic [8:0] STEP_4_V  = 9'h004;
  localparam logic [8:0] STEP_8_V  = 9'h008;
  localparam logic [8:0] STEP_16_V = 9'h010;
  localparam logic [7:0] DUTY_MAX  = 8'hff;
  localparam logic [7:0] DUTY_MIN  = 8'h00;
  localparam logic [7:0] DUTY_RST  = 8'h00;
  localparam logic [1:0] PH_RST    = 2'b00;
  localparam logic [1:0] DIV_RST   = 2'b00;
  localparam logic [1:0] INEN_RST  = 2'b00;
  localparam logic       GSEL_RST  = 1'b0;
  localparam logic       ON_RST    = 1'b0;
  localparam int         FRAME_BITS = 16;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int SYS_CLK_MHZ  = 50;
  localparam int REF_FAST_NS  = 4000;   // shorter reference period means too fast
  localparam int REF_SLOW_NS  = 80000;  // longer reference period means too slow
  localparam int DGL_NS       = 2000;
  localparam int REF_FAST_CYC = (REF_FAST_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int REF_SLOW_CYC = (REF_SLOW_NS * SYS_CLK_MHZ) / 1000;
  localparam int DGL_CYC      = (DGL_NS * SYS_CLK_MHZ + 999) / 1000;

endpackage

// ===== src/mpc_deglitch.sv
// deglitch filter for one direct control input
`timescale 1ns/1ps
module mpc_deglitch
  import mpc_pkg::*;
#(
  parameter int STABLE_CYC = DGL_CYC
)
(
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  input  wire logic pin_i,
  output logic      level_o
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        s1;
    logic        s2;
    logic [11:0] cnt;
    logic        level;
  } mpc_dgl_t;

  mpc_dgl_t q;
  mpc_dgl_t d;

  // output changes only once the pin held its new level long enough
  always_comb
  begin
    d    = q;
    d.s1 = pin_i;
    d.s2 = q.s1;
    if (q.s2 == q.level)
      d.cnt = 12'h000;
    else if (q.cnt == 12'(STABLE_CYC - 1))
    begin
      d.level = q.s2;
      d.cnt   = 12'h000;
    end
    else
      d.cnt = q.cnt + 12'h001;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      q <= '0;
    else
      q <= d;
  end

  assign level_o = q.level;

endmodule // mpc_deglitch

// ===== src/mpc_spi_rx.sv
// serial frame receiver: 16-bit words, taken at chip select release
`timescale 1ns/1ps
module mpc_spi_rx
  import mpc_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        sclk_i,
  input  wire logic        sdi_i,
  input  wire logic        chip_select_n_i,
  output logic [15:0]      word_o,
  output logic             valid_o
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        sclk_s1;
    logic        sclk_s2;
    logic        sclk_prev;
    logic        sdi_s1;
    logic        sdi_s2;
    logic        cs_s1;
    logic        cs_s2;
    logic        cs_prev;
    logic [15:0] shift;
    logic [4:0]  bits;
    logic [15:0] word;
    logic        valid;
  } mpc_rx_t;

  mpc_rx_t q;
  mpc_rx_t d;

  // data is sampled on the falling serial clock edge; frames of a
  // length other than sixteen are dropped so a torn frame writes nothing
  always_comb
  begin
    d           = q;
    d.sclk_s1   = sclk_i;
    d.sclk_s2   = q.sclk_s1;
    d.sclk_prev = q.sclk_s2;
    d.sdi_s1    = sdi_i;
    d.sdi_s2    = q.sdi_s1;
    d.cs_s1     = chip_select_n_i;
    d.cs_s2     = q.cs_s1;
    d.cs_prev   = q.cs_s2;
    d.valid     = 1'b0;
    if (q.cs_s2 && !q.cs_prev)
    begin
      d.valid = (q.bits == 5'(FRAME_BITS));
      d.word  = q.shift;
      d.bits  = 5'h00;
    end
    else if (q.cs_s2)
      d.bits = 5'h00;
    else if (!q.sclk_s2 && q.sclk_prev)
    begin
      d.shift = {q.shift[14:0], q.sdi_s2};
      if (q.bits != 5'h1f)
        d.bits = q.bits + 5'h01;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      q <= '{sclk_s1: 1'b0, sclk_s2: 1'b0, sclk_prev: 1'b0, sdi_s1: 1'b0, sdi_s2: 1'b0,
             cs_s1: 1'b1, cs_s2: 1'b1, cs_prev: 1'b1, shift: 16'h0000, bits: 5'h00,
             word: 16'h0000, valid: 1'b0};
    else
      q <= d;
  end

  assign word_o  = q.word;
  assign valid_o = q.valid;

endmodule // mpc_spi_rx

// ===== src/mpc_top.sv
// multichannel output pwm control: register decode, clock watch, pwm, direct inputs
//
// Behaviour
// - divider select picks divide by 4, 2, 1
// - failed reference clock gives full duty
// - all pwm timing from reference clock, 256 steps
// - control word: address, watch, phase, on, duty
// - on bits mirrored in output control register
// - sync bit resets counters at select release
// - sync bit clear leaves counters running
// - no pwm in fail mode or clock fail
// - global select bit picks individual or global duty
// - global duty from code 1001, bit 10 set
// - global channel keeps own phase and divider
// - increment adjusts channels one to five only
// - common direction bit: 0 down, 1 up
// - step field: none, 4, 8, 16
// - increments saturate at 00 and ff
// - direct inputs deglitched, wake, fail mode control
// - normal mode direct control by enable bits
// - divider bits written via prescaler registers only
`timescale 1ns/1ps
module mpc_top
  import mpc_pkg::*;
#(
  parameter int N_CH = CH_NUM,
  parameter int N_IN = IN_NUM
)
(
  input  wire logic             sys_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             sclk_i,
  input  wire logic             sdi_i,
  input  wire logic             chip_select_n_i,
  input  wire logic             ref_clk_i,
  input  wire logic             fail_mode_i,
  input  wire logic [N_IN-1:0]  direct_control_input_i,
  output logic      [N_CH-1:0]  out_o,
  output logic      [N_IN-1:0]  deglitched_input_o,
  output logic                  wake_o,
  output logic                  clk_fail_o
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  // everything the block remembers outside the receiver and the input filters, registered as one word; per-channel
  // fields are packed arrays indexed by channel number minus one
  typedef struct packed {
    logic                  ref_s1;
    logic                  ref_s2;
    logic                  ref_prev;
    logic [12:0]           per_cnt;
    logic                  clk_fail;
    logic [9:0]            base;
    logic [N_CH-1:0][7:0]  duty_value;
    logic [N_CH-1:0][1:0]  phase_select;
    logic [N_CH-1:0]       chan_on;
    logic [N_CH-1:0][1:0]  divider_select;
    logic [N_CH-1:0]       global_duty_select;
    logic [7:0]            global_duty_bits;
    logic [N_IN-1:0][1:0]  input_enable_bits;
    logic [N_CH-1:0]       out;
    logic [N_IN-1:0]       dgl;
    logic                  wake;
  } mpc_state_t;

  mpc_state_t q;
  mpc_state_t d;

  // receiver outputs and filtered inputs, all already on sys_clk
  logic [15:0]     rx_word;
  logic            rx_valid;
  logic [N_IN-1:0] deglitched_input;

  // ---------------------------------------------------------------
  // frame receiver and input filters
  // ---------------------------------------------------------------
  // the receiver resynchronises the serial pins itself, so the word and
  // its one-cycle valid strobe can be used here directly
  mpc_spi_rx u_rx (
    .sys_clk_i       (sys_clk_i),
    .rst_n_i         (rst_n_i),
    .sclk_i          (sclk_i),
    .sdi_i           (sdi_i),
    .chip_select_n_i (chip_select_n_i),
    .word_o          (rx_word),
    .valid_o         (rx_valid)
  );

  // a pulse shorter than the filter time never reaches the outputs
  // deglitch each input
  for (genvar g = 0; g < N_IN; g++)
  begin : g_dgl
    mpc_deglitch #(
      .STABLE_CYC (DGL_CYC)
    ) u_dgl (
      .sys_clk_i (sys_clk_i),
      .rst_n_i   (rst_n_i),
      .pin_i     (direct_control_input_i[g]),
      .level_o   (deglitched_input[g])
    );
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // every code is legal; the default arm is the sixteen-count step
  // step size decode
  function automatic logic [8:0] step_of(input logic [1:0] code);
    logic [8:0] v;
    unique case (code)
      STEP_NONE: v = 9'h000;
      STEP_4:    v = STEP_4_V;
      STEP_8:    v = STEP_8_V;
      default:   v = STEP_16_V;
    endcase
    return v;
  endfunction

  // clamp to the rails instead of wrapping
  function automatic logic [7:0] step_duty(input logic [7:0] duty, input logic [8:0] step,
                                           input logic up);
    logic [8:0] sum;
    // one bit wider, so an overflow shows up in bit 8
    sum = {1'b0, duty} + step;
    if (up)
      return sum[8] ? DUTY_MAX : sum[7:0];
    else if ({1'b0, duty} < step)
      return DUTY_MIN;
    else
      return 8'(({1'b0, duty} - step));
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    logic        ref_tick;
    logic [3:0]  adr;
    logic [2:0]  ch;
    logic [7:0]  sel_duty;
    logic [7:0]  pos;
    logic        pwm;
    logic [N_CH-1:0] dgl_ext;
    ref_tick = 1'b0;
    adr      = rx_word[ADR_MSB:ADR_LSB];
    ch       = 3'h0;
    sel_duty = 8'h00;
    pos      = 8'h00;
    pwm      = 1'b0;
    dgl_ext  = N_CH'(q.dgl);
    // fields not written below keep their held value
    d        = q;

    // reference clock edge detect after a two-stage synchroniser
    // only the first flop sees the raw pin; a late-settling sample
    // never reaches the edge detector
    d.ref_s1 = ref_clk_i;
    d.ref_s2 = q.ref_s1;
    d.ref_prev = q.ref_s2;
    ref_tick = q.ref_s2 && !q.ref_prev;

    // the first edge after a stall closes an over-long period, so it must
    // not clear the flag; only a period inside both limits does
    // period watch: a clock fails when too fast or too slow
    if (ref_tick)
    begin
      d.clk_fail = (q.per_cnt < 13'(REF_FAST_CYC)) ||
                   (q.per_cnt >= 13'(REF_SLOW_CYC));
      d.per_cnt  = 13'h0000;
    end
    else if (q.per_cnt >= 13'(REF_SLOW_CYC))
      d.clk_fail = 1'b1;
    else
      d.per_cnt = q.per_cnt + 13'h0001;

    // ten bits, so the divide-by-4 view still has 256 steps; wraps freely
    // one free counter; low bits act as the shared prescaler
    if (ref_tick)
      d.base = q.base + 10'h001;

    // an address code that is not decoded here changes nothing
    // register writes, decoded on chip select release
    if (rx_valid)
    begin
      if (adr >= ADR_CH_FIRST && adr <= ADR_CH_LAST)
      begin
        ch = 3'(adr - ADR_CH_FIRST);
        d.phase_select[ch] = rx_word[PH_MSB:PH_LSB];
        d.chan_on[ch]      = rx_word[ON_BIT];
        d.duty_value[ch]   = rx_word[DUTY_MSB:0];
      end
      case (adr)
        // only the shared base counter is cleared; settings stay
        // sync resets counters; clear bit does nothing
        ADR_INIT2:
          if (rx_word[SYNC_BIT])
            d.base = 10'h000;
        ADR_OUTCTL:
          d.chan_on = rx_word[N_CH-1:0];
        ADR_GLOBAL:
          if (rx_word[SEL_BIT])
            d.global_duty_bits = rx_word[DUTY_MSB:0];
          else
            d.global_duty_select = rx_word[N_CH-1:0];
        ADR_INEN:
          for (int k = 0; k < N_IN; k++)
            d.input_enable_bits[k] = rx_word[2*k +: 2];
        // bit 10 picks the lower or the upper three channels
        // two prescaler words, three channels each
        ADR_PRESC:
          for (int k = 0; k < N_CH / 2; k++)
            if (rx_word[SEL_BIT])
              d.divider_select[k + N_CH / 2] = rx_word[2*k +: 2];
            else
              d.divider_select[k] = rx_word[2*k +: 2];
        // saturating steps; global duty and channel six untouched
        // internal channels only; common direction
        ADR_INCR:
          for (int k = 0; k < INC_NUM; k++)
            d.duty_value[k] = step_duty(q.duty_value[k], step_of(rx_word[2*k +: 2]),
                                        rx_word[SGN_BIT]);
        default:
          d.base = d.base;  // other codes belong to other blocks
      endcase
    end

    // per channel output decision
    for (int i = 0; i < N_CH; i++)
    begin
      // duty source; own phase and divider still apply
      sel_duty = q.global_duty_select[i] ? q.global_duty_bits : q.duty_value[i];
      // divider picks which counter bits form the period
      if (q.divider_select[i][1])
        pos = q.base[7:0];
      else if (q.divider_select[i] == DIV_BY2)
        pos = q.base[8:1];
      else
        pos = q.base[9:2];
      // each phase step is a quarter period, added modulo 256
      pos = pos + {q.phase_select[i], 6'h00};
      // on while phased count below duty
      pwm = (pos < sel_duty);
      // priority: fail mode, direct input, clock fail, then pwm;
      // channels without a direct input go low in fail mode
      // fail mode hands outputs to the filtered inputs
      if (fail_mode_i)
        d.out[i] = (i < N_IN) ? dgl_ext[i] : 1'b0;
      // direct control overrides in normal mode
      else if (i < N_IN && q.input_enable_bits[i % N_IN] != INEN_RST)
        d.out[i] = dgl_ext[i];
      // full duty while the clock is bad
      else if (q.clk_fail)
        d.out[i] = q.chan_on[i];
      else
        d.out[i] = q.chan_on[i] && pwm;
    end

    // registered once more so the ports come straight from flops
    // filtered inputs wake the device
    d.dgl  = deglitched_input;
    d.wake = |deglitched_input;
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      // clear the record, then give the named fields their reset values
      q                    <= '0;
      // outputs stay plain on/off until a good period has been seen
      q.clk_fail           <= 1'b1;  // no reference seen yet
      q.duty_value         <= {N_CH{DUTY_RST}};
      q.phase_select       <= {N_CH{PH_RST}};
      q.divider_select     <= {N_CH{DIV_RST}};
      q.global_duty_select <= {N_CH{GSEL_RST}};
      q.chan_on            <= {N_CH{ON_RST}};
      q.input_enable_bits  <= {N_IN{INEN_RST}};
    end
    else
      q <= d;
  end

  // ---------------------------------------------------------------
  // outputs, all from the state register
  // ---------------------------------------------------------------
  // no logic between the register and the pins, so outputs cannot glitch
  assign out_o              = q.out;
  assign deglitched_input_o = q.dgl;
  assign wake_o             = q.wake;
  assign clk_fail_o         = q.clk_fail;

endmodule // mpc_top

// ===== verif/mpc_top_chk.sv
// pin-level assertions for the pwm control block
`timescale 1ns/1ps
module mpc_top_chk
  import mpc_pkg::*;
#(
  parameter int N_CH = CH_NUM,
  parameter int N_IN = IN_NUM
)
(
  input wire logic            sys_clk_i,
  input wire logic            rst_n_i,
  input wire logic            sclk_i,
  input wire logic            sdi_i,
  input wire logic            chip_select_n_i,
  input wire logic            ref_clk_i,
  input wire logic            fail_mode_i,
  input wire logic [N_IN-1:0] direct_control_input_i,
  input wire logic [N_CH-1:0] out_o,
  input wire logic [N_IN-1:0] deglitched_input_o,
  input wire logic            wake_o,
  input wire logic            clk_fail_o
);
  // ----------------------------------------
  // age counters
  // ----------------------------------------
  logic [12:0] ref_age_q;
  logic [7:0]  in_age_q;
  logic        ref_q;

  // saturating, so a stopped clock never wraps back to young
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ref_q     <= 1'b0;
      ref_age_q <= 13'h1fff;
      in_age_q  <= 8'h00;
    end
    else
    begin
      ref_q <= ref_clk_i;
      if (ref_clk_i && !ref_q)
        ref_age_q <= 13'h0000;
      else if (ref_age_q != 13'h1fff)
        ref_age_q <= ref_age_q + 13'h0001;
      if (!direct_control_input_i[0])
        in_age_q <= 8'h00;
      else if (in_age_q != 8'hff)
        in_age_q <= in_age_q + 8'h01;
    end
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // eight quiet cycles: no frame, no fail mode, filtered inputs still
  sequence s_calm(logic f);
    (clk_fail_o == f && chip_select_n_i && !fail_mode_i && $stable(deglitched_input_o)) [*8];
  endsequence

  property p_rst;
    $rose(rst_n_i) |-> clk_fail_o && out_o == '0 && !wake_o;
  endproperty
  property p_wake;
    wake_o == |deglitched_input_o;
  endproperty
  property p_dgl;
    $rose(deglitched_input_o[0]) |-> in_age_q >= 8'd98;
  endproperty
  property p_fail_out;
    (fail_mode_i && $stable(deglitched_input_o)) [*4]
      |-> out_o[N_IN-1:0] == deglitched_input_o && out_o[N_CH-1:N_IN] == '0;
  endproperty
  property p_slow;
    ref_age_q >= 13'd4020 |-> clk_fail_o;
  endproperty
  property p_fast;
    $rose(ref_clk_i) && ref_age_q < 13'd150 |-> ##[1:8] clk_fail_o;
  endproperty
  property p_no_pwm;
    s_calm(1'b1) |-> $stable(out_o);
  endproperty
  property p_pwm_edge;
    s_calm(1'b0) ##0 !$stable(out_o) |-> ref_age_q <= 13'd10;
  endproperty

  a_rst: assert property (p_rst) else $error("bad state after reset");
  a_wake: assert property (p_wake) else $error("wake differs from inputs");
  a_dgl: assert property (p_dgl) else $error("short pulse passed filter");
  a_fail_out: assert property (p_fail_out) else $error("fail mode output wrong");
  a_slow: assert property (p_slow) else $error("stopped clock not flagged");
  a_fast: assert property (p_fast) else $error("fast clock not flagged");
  a_no_pwm: assert property (p_no_pwm) else $error("output moved in clock fail");
  a_pwm_edge: assert property (p_pwm_edge) else $error("output moved without tick");
endmodule // mpc_top_chk

bind mpc_top mpc_top_chk #(.N_CH(N_CH), .N_IN(N_IN)) i_chk (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk_i), .sdi_i(sdi_i),
  .chip_select_n_i(chip_select_n_i), .ref_clk_i(ref_clk_i), .fail_mode_i(fail_mode_i),
  .direct_control_input_i(direct_control_input_i), .out_o(out_o),
  .deglitched_input_o(deglitched_input_o), .wake_o(wake_o), .clk_fail_o(clk_fail_o)
);

// ===== verif/mpc_host.sv
// serial host model writing configuration frames
`timescale 1ns/1ps
module mpc_host
(
  input  wire logic sys_clk_i,
  output logic      sclk_o,
  output logic      sdi_o,
  output logic      chip_select_n_o
);
  // idle bus: clock still, select high
  initial
  begin
    sclk_o          = 1'b0;
    sdi_o           = 1'b0;
    chip_select_n_o = 1'b1;
  end

  // address first, msb first
  // a bit count other than 16 gives a frame the block must drop; hold sets speed
  task automatic send(input logic [15:0] w, input int nbits, input int hold);
    @(posedge sys_clk_i);
    chip_select_n_o <= 1'b0;
    for (int i = nbits - 1; i >= 0; i--)
    begin
      repeat (hold) @(posedge sys_clk_i);
      sdi_o <= w[i];
      repeat (hold) @(posedge sys_clk_i);
      sclk_o <= 1'b1;
      repeat (hold) @(posedge sys_clk_i);
      sclk_o <= 1'b0;
    end
    repeat (4) @(posedge sys_clk_i);
    chip_select_n_o <= 1'b1;
    sdi_o           <= ~sdi_o;  // released line must not keep the last bit
    repeat (8) @(posedge sys_clk_i);
  endtask
endmodule // mpc_host

// ===== verif/tb.sv
// self-checking bench for the multichannel pwm control block
`timescale 1ns/1ps
module tb;
  // ----------------------------------------
  // rows: three frames, ticks after resync, expected outputs
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] w0;
    logic [15:0] w1;
    logic [15:0] w2;
    logic [7:0]  n;
    logic [5:0]  exp_out;
  } mpc_row_t;

  // duties stay in the edge shaping range, except where steps hit the rails
  localparam mpc_row_t TBL [13] = '{
    '{16'h2107, 16'h3108, 16'h1000, 8'd7,  6'h02},
    '{16'h1000, 16'h1000, 16'h1000, 8'd3,  6'h03},
    '{16'h2307, 16'h1000, 16'h1000, 8'd3,  6'h02},
    '{16'h9003, 16'h9440, 16'h1000, 8'd10, 6'h02},
    '{16'h9000, 16'h8000, 16'h1000, 8'd3,  6'h00},
    '{16'h2007, 16'h8001, 16'h1000, 8'd3,  6'h01},
    '{16'he40d, 16'h8003, 16'h1000, 8'd11, 6'h02},
    '{16'he003, 16'h1000, 16'h1000, 8'd1,  6'h02},
    '{16'h21f0, 16'he403, 16'h1000, 8'd20, 6'h03},
    '{16'h7110, 16'he3ff, 16'h1000, 8'd40, 6'h21},
    '{16'hc015, 16'h2110, 16'h8001, 8'd20, 6'h01},
    '{16'h1000, 16'h1000, 16'h1000, 8'd40, 6'h00},
    '{16'hc420, 16'h8023, 16'he408, 8'd26, 6'h03}
  };

  logic       sys_clk   = 1'b0;
  logic       rst_n     = 1'b0;
  logic       ref_clk   = 1'b0;
  logic       ref_run   = 1'b1;
  int         ref_half  = 2200;
  logic       fail_mode = 1'b0;
  logic [3:0] dci       = 4'h0;
  logic       sclk;
  logic       sdi;
  logic       cs_n;
  logic [5:0] out;
  logic [3:0] dgl;
  logic       wake;
  logic       clk_fail;
  int         error_cnt       = 0;
  int         samples_checked = 0;

  // reference clock is unrelated to the system clock and can stop low
  always #10 sys_clk = ~sys_clk;
  always
  begin
    #(ref_half);
    ref_clk = ref_run & ~ref_clk;
  end

  mpc_top i_dut (
    .sys_clk_i(sys_clk), .rst_n_i(rst_n), .sclk_i(sclk), .sdi_i(sdi),
    .chip_select_n_i(cs_n), .ref_clk_i(ref_clk), .fail_mode_i(fail_mode),
    .direct_control_input_i(dci), .out_o(out), .deglitched_input_o(dgl),
    .wake_o(wake), .clk_fail_o(clk_fail)
  );
  mpc_host i_host (.sys_clk_i(sys_clk), .sclk_o(sclk), .sdi_o(sdi), .chip_select_n_o(cs_n));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic stop_test();
    $display("compares %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic give_up(input string what);
    error_cnt++;
    $display("wrong value at %0t: %s timed out", $time, what);
    stop_test();
  endtask

  // bounded wait on the clock-fail flag
  task automatic wait_fail(input logic lvl, input int lim);
    samples_checked++;
    for (int c = 0; c < lim && clk_fail !== lvl; c++)
      @(posedge sys_clk);
    if (clk_fail !== lvl)
      give_up("clock flag");
  endtask

  // count reference rising edges; a stalled clock ends the run
  task automatic ref_ticks(input int n);
    int   k;
    logic p;
    k = 0;
    p = ref_clk;
    for (int c = 0; c < 300 * n && k < n; c++)
    begin
      @(posedge sys_clk);
      if (ref_clk && !p)
        k++;
      p = ref_clk;
    end
    if (k < n)
      give_up("reference");
  endtask

  // resync inside one reference period, then let n ticks pass
  task automatic sync_run(input int n);
    ref_ticks(1);
    i_host.send(16'h1002, 16, 3);
    ref_ticks(n);
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    check({clk_fail, wake, out}, 8'h80, "reset");
    wait_fail(1'b0, 1000);
    i_host.send(16'hc02a, 16, 3);
    for (int i = 0; i < 13; i++)
    begin
      i_host.send(TBL[i].w0, 16, 3);
      i_host.send(TBL[i].w1, 16, 3);
      i_host.send(TBL[i].w2, 16, 3);
      sync_run(TBL[i].n);
      check({2'b00, out}, {2'b00, TBL[i].exp_out}, "row");
    end
    // a word without the sync bit leaves the counters running
    sync_run(24);
    i_host.send(16'h1000, 16, 3);
    ref_ticks(10);
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    check({2'b00, out}, 8'h00, "no sync");
    // stopped reference: on bits give full duty; a slow short frame is dropped
    ref_run = 1'b0;
    wait_fail(1'b1, 4300);
    @(negedge sys_clk);
    check({2'b00, out}, 8'h23, "full duty");
    i_host.send(16'h8000, 15, 15);
    @(negedge sys_clk);
    check({2'b00, out}, 8'h23, "short frame");
    i_host.send(16'h8002, 16, 3);
    @(negedge sys_clk);
    check({2'b00, out}, 8'h02, "mirror");
    // too fast a reference is a failure too
    ref_run = 1'b1;
    wait_fail(1'b0, 2000);
    ref_half = 500;
    wait_fail(1'b1, 600);
    ref_half = 2200;
    wait_fail(1'b0, 2000);
    // direct input: glitch filtered, steady level drives channel one
    i_host.send(16'hb001, 16, 3);
    dci <= 4'h1;
    repeat (40) @(posedge sys_clk);
    dci <= 4'h0;
    repeat (120) @(posedge sys_clk);
    @(negedge sys_clk);
    check({3'b000, wake, dgl}, 8'h00, "glitch");
    @(posedge sys_clk);
    dci <= 4'h1;
    repeat (120) @(posedge sys_clk);
    @(negedge sys_clk);
    check({2'b00, wake, dgl, out[0]}, 8'h23, "input on");
    @(posedge sys_clk);
    fail_mode <= 1'b1;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    check({2'b00, out}, 8'h01, "fail mode");
    @(posedge sys_clk);
    dci <= 4'h0;
    repeat (120) @(posedge sys_clk);
    @(negedge sys_clk);
    check({1'b0, wake, out}, 8'h00, "input off");
    stop_test();
  end
endmodule // tb
